//--- verilog/reset_source_pkg.sv
// package: reset cause register layout, vectors and timing counts
`default_nettype none
package reset_source_pkg;
    // register map
    localparam logic [3:0] cause_offset = 4'h0;
    localparam logic [3:0] config_offset = 4'h1;
    // reset cause bit layout (8-bit register)
    localparam int bit_power_on = 7;
    localparam int bit_external = 6;
    localparam int bit_watchdog = 5;
    localparam int bit_bad_opcode = 4;
    localparam int bit_bad_fetch = 3;
    localparam int bit_monitor = 2;
    localparam int bit_undervoltage = 1;
    localparam logic [7:0] cause_reset_value = 8'h80;
    // config register: bit 0 stop enable, bit 1 monitor mode
    localparam int bit_stop_enable = 0;
    localparam int bit_monitor_mode = 1;
    localparam logic [1:0] config_reset_value = 2'h0;
    // vector addresses
    localparam logic [15:0] vector_high_normal = 16'hfffe;
    localparam logic [15:0] vector_high_monitor = 16'hfefe;
    localparam logic [15:0] vector_low = 16'hffff;
    localparam logic [15:0] watchdog_clear_addr = 16'hffff;
    localparam logic [7:0] blank_byte = 8'hff;
    // timing in oscillator cycles
    localparam int drive_cycles = 32;
    localparam int hold_cycles = 32;
    localparam int sample_cycles = 32;
    localparam int stabilize_cycles = 4096;
    localparam int bus_div = 4;
endpackage : reset_source_pkg
`default_nettype wire

//--- verilog/reset_source_controller.sv
// reset sequencer with reset-cause status register
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - vector fetch address depends on monitor mode
// - reset restarts bus clock at oscillator divided four
// - reset aborts instruction; control bits kept, only rst clears them
// - low reset line sets external flag
// - internal source drives line 32, holds 32
// - power-on holds clocks 4096, line low
// - after stabilization release line 32, cpu 64
// - power-on sets own flag, clears others
// - watchdog overflow resets, sets watchdog flag
// - undervoltage drives line while low, then 4096
// - illegal opcode resets, sets bad opcode flag
// - stop without stop enable is illegal opcode
// - fetch from unmapped address resets, sets flag
// - data access to unmapped address is harmless
// - cause register read-only, read clears all but flags set in the same cycle
// - flags accumulate until a read
// - sample line 32 after release, maybe external
// - monitor entry sets monitor flag
// - interrupt waits for instruction completion
module reset_source_controller (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic power_on_pulse,
    input wire logic supply_low,
    input wire logic watchdog_overflow,
    input wire logic illegal_opcode,
    input wire logic stop_executed,
    input wire logic opcode_fetch,
    input wire logic addr_unmapped,
    input wire logic monitor_entry,
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic reset_line_in,
    output logic reset_line_out,
    output logic reset_line_oe_n,
    output logic cpu_in_reset,
    output logic clocks_enabled,
    output logic bus_clk_en,
    output logic vector_fetch,
    output logic [15:0] vector_addr_hi,
    output logic [15:0] vector_addr_lo,
    output logic abort_instr,
    output logic interrupt_take,
    output logic watchdog_clear,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    output logic [7:0] reg_rdata
);
    typedef enum logic [4:0] {
        st_run = 5'b0_0001,
        st_stab = 5'b0_0010,
        st_drive = 5'b0_0100,
        st_hold = 5'b0_1000,
        st_fetch = 5'b1_0000
    } seq_state_t;

    seq_state_t state_r;
    logic [12:0] count_r;
    logic [5:0] sample_cnt_r;
    logic sampling_r;
    logic [7:0] cause_r;
    logic [1:0] config_r;
    logic [1:0] div_r;
    logic long_seq_r;
    logic ext_req;
    logic bad_op;
    logic bad_fetch;
    logic int_req;
    logic any_req;
    logic cause_rd;
    logic [7:0] set_bits;

    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    assign bad_op = illegal_opcode | (stop_executed & ~config_r[reset_source_pkg::bit_stop_enable]);
    assign bad_fetch = opcode_fetch & addr_unmapped;
    assign ext_req = ~reset_line_in & (state_r == st_run);
    assign int_req = watchdog_overflow | bad_op | bad_fetch | monitor_entry;
    assign any_req = power_on_pulse | supply_low | int_req | ext_req;
    assign cause_rd = reg_rd && reg_addr == reset_source_pkg::cause_offset;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= st_stab;
            count_r <= 13'h0000;
            long_seq_r <= 1'b1;
        end else if (power_on_pulse || supply_low) begin
            state_r <= st_stab;
            count_r <= 13'h0000;
            long_seq_r <= 1'b1;
        end else if (state_r == st_run && any_req) begin
            state_r <= ext_req ? st_hold : st_drive;
            count_r <= 13'h0000;
            long_seq_r <= 1'b0;
        end else begin
            case (state_r)
                st_stab: begin
                    if (count_r == 13'(reset_source_pkg::stabilize_cycles - 1)) begin
                        state_r <= st_drive;
                        count_r <= 13'h0000;
                    end else begin
                        count_r <= count_r + 13'h0001;
                    end
                end
                st_drive: begin
                    if (count_r == 13'(reset_source_pkg::drive_cycles - 1)) begin
                        state_r <= st_hold;
                        count_r <= 13'h0000;
                    end else begin
                        count_r <= count_r + 13'h0001;
                    end
                end
                st_hold: begin
                    // outside power-on and low-supply sequences, an external party still holding the line keeps us here
                    if (!reset_line_in && !long_seq_r && count_r == 13'h0000) begin
                        count_r <= 13'h0000;
                    end else if (count_r == 13'(reset_source_pkg::hold_cycles - 1)) begin
                        state_r <= st_fetch;
                        count_r <= 13'h0000;
                    end else begin
                        count_r <= count_r + 13'h0001;
                    end
                end
                st_fetch: begin
                    state_r <= st_run;
                end
                default: begin
                    state_r <= st_run;
                end
            endcase
        end
    end

    // ----------------------------------------
    // line sampling after release
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sampling_r <= 1'b0;
            sample_cnt_r <= 6'h00;
        end else if (state_r == st_drive && count_r == 13'(reset_source_pkg::drive_cycles - 1)) begin
            sampling_r <= 1'b1;
            sample_cnt_r <= 6'h00;
        end else if (sampling_r) begin
            if (sample_cnt_r == 6'(reset_source_pkg::sample_cycles - 1)) begin
                sampling_r <= 1'b0;
            end
            sample_cnt_r <= sample_cnt_r + 6'h01;
        end
    end

    // ----------------------------------------
    // bus clock divider
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst || state_r != st_run) begin
            div_r <= 2'h0;
        end else begin
            div_r <= (div_r == 2'(reset_source_pkg::bus_div - 1)) ? 2'h0 : div_r + 2'h1;
        end
    end

    // ----------------------------------------
    // cause register
    // ----------------------------------------
    always_comb begin
        set_bits = 8'h00;
        if (state_r == st_run) begin
            set_bits[reset_source_pkg::bit_external] = ext_req;
            set_bits[reset_source_pkg::bit_watchdog] = watchdog_overflow;
            set_bits[reset_source_pkg::bit_bad_opcode] = bad_op;
            set_bits[reset_source_pkg::bit_bad_fetch] = bad_fetch;
            set_bits[reset_source_pkg::bit_monitor] = monitor_entry;
        end
        set_bits[reset_source_pkg::bit_undervoltage] = supply_low;
        if (sampling_r && sample_cnt_r == 6'(reset_source_pkg::sample_cycles - 1)) begin
            set_bits[reset_source_pkg::bit_external] = ~reset_line_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cause_r <= reset_source_pkg::cause_reset_value;
        end else if (power_on_pulse) begin
            cause_r <= reset_source_pkg::cause_reset_value;
        end else if (cause_rd) begin
            cause_r <= set_bits; // new event wins over read clear
        end else begin
            cause_r <= cause_r | set_bits;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            config_r <= reset_source_pkg::config_reset_value;
        end else if (reg_wr && reg_addr == reset_source_pkg::config_offset) begin
            config_r <= reg_wdata[1:0];
        end
    end

    // writes to the cause register are ignored: read-only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == reset_source_pkg::cause_offset) begin
                reg_rdata <= cause_r;
            end else if (reg_addr == reset_source_pkg::config_offset) begin
                reg_rdata <= {6'h00, config_r};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reset_line_out = 1'b0;
    assign reset_line_oe_n = ~(state_r == st_stab || state_r == st_drive);
    assign cpu_in_reset = state_r != st_run;
    assign clocks_enabled = state_r != st_stab;
    assign bus_clk_en = state_r == st_run && div_r == 2'h0;
    assign vector_fetch = state_r == st_fetch;
    assign vector_addr_hi = config_r[reset_source_pkg::bit_monitor_mode] ?
        reset_source_pkg::vector_high_monitor : reset_source_pkg::vector_high_normal;
    assign vector_addr_lo = reset_source_pkg::vector_low;
    assign abort_instr = state_r == st_run && any_req;
    assign interrupt_take = state_r == st_run && !any_req && irq_pending && instr_done;
    assign watchdog_clear = cpu_wr && cpu_addr == reset_source_pkg::watchdog_clear_addr;
endmodule : reset_source_controller
`default_nettype wire

//--- dv/reset_source_controller_asserts.sv
// assertion checker for the reset sequencer ports
`timescale 1ns/1ns
`default_nettype none
module reset_source_controller_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic power_on_pulse,
    input wire logic supply_low,
    input wire logic watchdog_overflow,
    input wire logic illegal_opcode,
    input wire logic opcode_fetch,
    input wire logic addr_unmapped,
    input wire logic instr_done,
    input wire logic reset_line_oe_n,
    input wire logic cpu_in_reset,
    input wire logic clocks_enabled,
    input wire logic bus_clk_en,
    input wire logic vector_fetch,
    input wire logic abort_instr,
    input wire logic interrupt_take,
    input wire logic watchdog_clear,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----
    // cycle counters: 4096 is too long for a repetition
    // ----
    logic [12:0] stab_cnt;
    logic [6:0] drv_cnt;
    always_ff @(posedge core_clk) begin
        if (rst || clocks_enabled || supply_low || power_on_pulse) begin
            stab_cnt <= '0;
        end else begin
            stab_cnt <= stab_cnt + 13'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        // a power-on or low supply in mid-drive must not leave a stale count behind
        if (rst || reset_line_oe_n || !clocks_enabled) begin
            drv_cnt <= '0;
        end else begin
            drv_cnt <= drv_cnt + 7'h1;
        end
    end
    a_stab_len: assert property ($rose(clocks_enabled) |-> stab_cnt == 13'h1000)
        else $error("clock hold length wrong");
    a_stab_drive: assert property (!clocks_enabled |-> !reset_line_oe_n)
        else $error("line released during clock hold");
    a_supply_drive: assert property (supply_low |=> !reset_line_oe_n && !clocks_enabled)
        else $error("low supply not holding line");
    a_drive_len: assert property ($rose(reset_line_oe_n) |-> drv_cnt == 7'h20)
        else $error("line drive length wrong");
    a_hold_len: assert property ($rose(reset_line_oe_n) |-> cpu_in_reset[*8] ##25 vector_fetch)
        else $error("vector fetch not 32 after release");
    a_abort_now: assert property ((watchdog_overflow || illegal_opcode) && !cpu_in_reset |-> abort_instr)
        else $error("instruction not aborted");
    a_bus_div: assert property (bus_clk_en |=> !bus_clk_en[*3])
        else $error("bus clock faster than quarter");
    a_wdog_clear: assert property (cpu_wr && cpu_addr == 16'hffff |-> watchdog_clear)
        else $error("watchdog clear missed");
    a_data_safe: assert property (addr_unmapped && !opcode_fetch && !cpu_in_reset |=> !cpu_in_reset)
        else $error("data access caused reset");
    a_irq_wait: assert property (interrupt_take |-> instr_done && !cpu_in_reset)
        else $error("interrupt taken mid instruction");
endmodule : reset_source_controller_asserts
`default_nettype wire

//--- dv/reset_line_party.sv
// model of outside parties sharing the open reset line
`timescale 1ns/1ns
`default_nettype none
module reset_line_party (
    input wire logic reset_line_oe_n,
    input wire logic pull_low,
    output logic reset_line
);
    // pulled up: high unless the device or an outside party sinks it
    assign reset_line = reset_line_oe_n && !pull_low;
endmodule : reset_line_party
`default_nettype wire

//--- dv/tb_reset_source_controller.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_reset_source_controller;
    logic core_clk = 0, rst = 1, supply_low = 0, pull = 0, reg_wr = 0, reg_rd = 0, cpu_wr = 0;
    logic instr_done = 0, irq_pending = 0, line, oe_n, fetch, in_rst;
    logic [6:0] src = '0;
    logic [3:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic [15:0] cpu_addr = '0, vhi, vlo;
    logic [6:0] mask [4] = '{7'h02, 7'h04, 7'h08, 7'h30};
    logic [7:0] flag [4] = '{8'h20, 8'h10, 8'h10, 8'h08};
    int miscompares = 0, num_checks = 0;
    always #25 core_clk = ~core_clk;
    reset_source_controller reset_source_controller_inst (.core_clk(core_clk), .rst(rst),
        .power_on_pulse(src[0]), .supply_low(supply_low), .watchdog_overflow(src[1]),
        .illegal_opcode(src[2]), .stop_executed(src[3]), .opcode_fetch(src[4]),
        .addr_unmapped(src[5]), .monitor_entry(src[6]), .instr_done(instr_done),
        .irq_pending(irq_pending), .reset_line_in(line), .reset_line_out(),
        .reset_line_oe_n(oe_n), .cpu_in_reset(in_rst), .clocks_enabled(), .bus_clk_en(),
        .vector_fetch(fetch), .vector_addr_hi(vhi), .vector_addr_lo(vlo), .abort_instr(),
        .interrupt_take(), .watchdog_clear(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .reg_rdata(reg_rdata));
    reset_line_party reset_line_party_inst (.reset_line_oe_n(oe_n), .pull_low(pull),
        .reset_line(line));
    // ----
    // access tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic hit(input logic [6:0] m);
        @(posedge core_clk);
        src <= m;
        @(posedge core_clk);
        src <= '0;
    endtask : hit
    // bounded wait: power-on path needs about 4200 cycles
    task automatic wf(input logic [15:0] hi);
        int n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (fetch !== 1'b1 && n < 6000);
        chk(fetch, 1'b1);
        chk(vhi, hi);
        chk(vlo, 16'hffff);
    endtask : wf
    task automatic close_out;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        #3000000;
        miscompares++;
        close_out();
    end
    // ----
    // scenarios
    // ----
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 0;
        wf(16'hfffe);
        rd(4'h0, 8'h80);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h00);
        foreach (mask[i]) begin
            hit(mask[i]);
            wf(16'hfffe);
            rd(4'h0, flag[i]);
        end
        hit(7'h02);
        wf(16'hfffe);
        hit(7'h04);
        wf(16'hfffe);
        rd(4'h0, 8'h30);
        wr(4'h1, 8'h01);
        hit(7'h08);
        hit(7'h20);
        cpu_wr <= 1;
        cpu_addr <= 16'hffff;
        irq_pending <= 1;
        @(posedge core_clk);
        cpu_wr <= 0;
        instr_done <= 1;
        repeat (70) @(posedge core_clk);
        chk(in_rst, 1'b0);
        rd(4'h0, 8'h00);
        pull <= 1;
        repeat (5) @(posedge core_clk);
        pull <= 0;
        wf(16'hfffe);
        rd(4'h0, 8'h40);
        supply_low <= 1;
        repeat (10) @(posedge core_clk);
        #1 chk(oe_n, 1'b0);
        @(posedge core_clk);
        supply_low <= 0;
        wf(16'hfffe);
        rd(4'h0, 8'h02);
        wr(4'h1, 8'h02);
        hit(7'h40);
        wf(16'hfefe);
        rd(4'h0, 8'h04);
        wr(4'h1, 8'h00);
        hit(7'h02);
        wf(16'hfffe);
        hit(7'h01);
        wf(16'hfffe);
        rd(4'h0, 8'h80);
        close_out();
    end
endmodule : tb_reset_source_controller
bind reset_source_controller reset_source_controller_asserts chk_inst (.*);
`default_nettype wire
